// file: ssp_regs.svh
// constants for the serial memory programming controller
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SSP_CLK_HZ          20000000
`define SSP_PWRUP_US        20000
`define SSP_FLASH_WAIT_US   4500
`define SSP_EEPROM_WAIT_US  9000
`define SSP_FUSE_WAIT_US    4500
`define SSP_ERASE_WAIT_US   9000
`define SSP_SCK_HALF_NS     200
`define SSP_RST_PULSE_NS    1000
`define SSP_US2CYC(u)       ((u) * (`SSP_CLK_HZ / 1000000))
`define SSP_NS2CYC_UP(n)    (((n) * (`SSP_CLK_HZ / 1000000) + 999) / 1000)

// ****************************************************************
// instruction bytes
// ****************************************************************
`define SSP_OP_ENABLE       8'hac
`define SSP_ENABLE_ECHO     8'h53
`define SSP_ERASE_B2        8'h80
`define SSP_OP_POLL         8'hf0
`define SSP_OP_LOAD_LO      8'h40
`define SSP_OP_LOAD_HI      8'h48
`define SSP_OP_WR_PAGE      8'h4c
`define SSP_OP_RD_LO        8'h20
`define SSP_OP_RD_HI        8'h28
`define SSP_OP_RD_EE        8'ha0
`define SSP_OP_WR_EE        8'hc0
`define SSP_PAGE_MASK       16'hffc0
`define SSP_FILL            8'h00
`define SSP_ECHO_MSB        15
`define SSP_ECHO_LSB        8

`endif

// file: ssp_pkg.sv
// types shared by the serial memory programming controller
`default_nettype none
package ssp_pkg;

    typedef enum logic [3:0] {
        SSP_CMD_ENTER      = 4'h0,
        SSP_CMD_ERASE      = 4'h1,
        SSP_CMD_LOAD_LO    = 4'h2,
        SSP_CMD_LOAD_HI    = 4'h3,
        SSP_CMD_WRITE_PAGE = 4'h4,
        SSP_CMD_WRITE_EE   = 4'h5,
        SSP_CMD_READ_LO    = 4'h6,
        SSP_CMD_READ_HI    = 4'h7,
        SSP_CMD_READ_EE    = 4'h8,
        SSP_CMD_POLL       = 4'h9,
        SSP_CMD_RELEASE    = 4'ha
    } ssp_cmd_e;

    typedef enum logic [5:0] {
        SSP_ST_BOOT  = 6'h01,
        SSP_ST_PWRUP = 6'h02,
        SSP_ST_IDLE  = 6'h04,
        SSP_ST_SEND  = 6'h08,
        SSP_ST_WAIT  = 6'h10,
        SSP_ST_PULSE = 6'h20
    } ssp_state_e;

    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [4:0]  bitIdx;
        logic [31:0] tx;
        logic [31:0] rx;
        logic        sck;
        logic        mosi;
        logic        done;
    } ssp_shift_s;

    typedef struct packed {
        logic        busy;
        logic [19:0] cnt;
        logic        done;
    } ssp_delay_s;

    typedef struct packed {
        ssp_state_e  state;
        ssp_cmd_e    op;
        logic [15:0] addr;
        logic [7:0]  data;
        logic [31:0] frame;
        logic        cmdReady;
        logic        rspValid;
        logic [7:0]  rspData;
        logic        rspError;
        logic        synced;
        logic        devResetN;
        logic        pendEnter;
        logic [3:0]  retries;
        logic        loValid;
        logic [15:0] loAddr;
        logic        shiftStart;
        logic        delayLoad;
        logic [19:0] delayCount;
        logic        misoMeta;
        logic        misoSync;
    } ssp_ctl_s;

endpackage
`default_nettype wire

// file: ssp_delay.sv
// down-counter that marks the end of a programmed wait
`default_nettype none
module ssp_delay
    import ssp_pkg::*;
#(
    parameter int W = 20
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstN,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // status
    output logic              done
);
    ssp_delay_s r_reg;
    ssp_delay_s r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (load) begin
            r_next.busy = 1'b1;
            // zero would wrap to the longest wait, so it counts as one
            r_next.cnt  = (count == '0) ? 20'h00001 : 20'(count);
        end else if (r_reg.busy) begin
            if (r_reg.cnt == 20'h00001) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt - 20'h00001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;
endmodule // ssp_delay
`default_nettype wire

// file: ssp_shift.sv
// shifts one four-byte instruction out and its answer in
`default_nettype none
module ssp_shift
    import ssp_pkg::*;
#(
    parameter int HALF = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstN,
    // frame
    input  wire logic        start,
    input  wire logic [31:0] txFrame,
    output logic [31:0]      rxFrame,
    output logic             done,
    // link
    input  wire logic        misoSync,
    output logic             sck,
    output logic             mosi
);
    localparam logic [15:0] HALF_LAST = 16'(HALF - 1);

    ssp_shift_s r_reg;
    ssp_shift_s r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (start && !r_reg.busy) begin
            r_next.busy   = 1'b1;
            r_next.tx     = txFrame;
            r_next.mosi   = txFrame[31];
            r_next.sck    = 1'b0;
            r_next.cnt    = HALF_LAST;
            r_next.bitIdx = 5'h1f;
        end else if (r_reg.busy) begin
            if (r_reg.cnt != 16'h0000) begin
                r_next.cnt = r_reg.cnt - 16'h0001;
            end else if (!r_reg.sck) begin
                // mosi has been steady a full low phase before this rise
                r_next.sck = 1'b1;
                r_next.cnt = HALF_LAST;
            end else begin
                // miso changed at the previous fall, so late high is safe
                r_next.rx  = {r_reg.rx[30:0], misoSync};
                r_next.sck = 1'b0;
                r_next.cnt = HALF_LAST;
                if (r_reg.bitIdx == 5'h00) begin
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                end else begin
                    r_next.bitIdx = r_reg.bitIdx - 5'h01;
                    r_next.tx     = {r_reg.tx[30:0], 1'b0};
                    r_next.mosi   = r_reg.tx[30];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rxFrame = r_reg.rx;
    assign done    = r_reg.done;
    assign sck     = r_reg.sck;
    assign mosi    = r_reg.mosi;
endmodule // ssp_shift
`default_nettype wire

// file: ssp_programmer.sv
// in-system serial programmer that drives the target's reset and spi pins
`include "ssp_regs.svh"
`default_nettype none
module ssp_programmer
    import ssp_pkg::*;
#(
    parameter int PWRUP_CYC   = `SSP_US2CYC(`SSP_PWRUP_US),
    parameter int FLASH_CYC   = `SSP_US2CYC(`SSP_FLASH_WAIT_US),
    parameter int EEPROM_CYC  = `SSP_US2CYC(`SSP_EEPROM_WAIT_US),
    parameter int ERASE_CYC   = `SSP_US2CYC(`SSP_ERASE_WAIT_US),
    parameter int SCK_HALF    = `SSP_NS2CYC_UP(`SSP_SCK_HALF_NS),
    parameter int PULSE_CYC   = `SSP_NS2CYC_UP(`SSP_RST_PULSE_NS),
    parameter int RETRIES     = 3
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // command
    input  wire logic        cmdValid,
    input  wire ssp_cmd_e    cmdOp,
    input  wire logic [15:0] cmdAddr,
    input  wire logic [7:0]  cmdData,
    output logic             cmdReady,
    // response
    output logic             rspValid,
    output logic [7:0]       rspData,
    output logic             rspError,
    // status
    output logic             linkSynced,
    // target pins
    output logic             devResetN,
    output logic             sck,
    output logic             mosi,
    input  wire logic        miso
);
    // ****************************************************************
    // wait lengths
    // ****************************************************************
    localparam logic [19:0] PWRUP_LEN  = 20'(PWRUP_CYC);
    localparam logic [19:0] FLASH_LEN  = 20'(FLASH_CYC);
    localparam logic [19:0] EEPROM_LEN = 20'(EEPROM_CYC);
    localparam logic [19:0] ERASE_LEN  = 20'(ERASE_CYC);
    localparam logic [19:0] PULSE_LEN  = 20'(PULSE_CYC);
    localparam logic [3:0]  RETRY_MAX  = 4'(RETRIES);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rstPipe_reg;
    logic       rstN;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    // release on an edge, so no flop leaves reset early
    assign rstN = rstPipe_reg[1];

    // ****************************************************************
    // helpers
    // ****************************************************************
    ssp_ctl_s    r_reg;
    ssp_ctl_s    r_next;
    logic [31:0] rxFrame;
    logic        shiftDone;
    logic        delayDone;

    ssp_shift #(
        .HALF     (SCK_HALF)
    ) u_shift (
        .clk      (clk_sys),
        .rstN     (rstN),
        .start    (r_reg.shiftStart),
        .txFrame  (r_reg.frame),
        .rxFrame  (rxFrame),
        .done     (shiftDone),
        .misoSync (r_reg.misoSync),
        .sck      (sck),
        .mosi     (mosi)
    );

    ssp_delay #(
        .W        (20)
    ) u_delay (
        .clk      (clk_sys),
        .rstN     (rstN),
        .load     (r_reg.delayLoad),
        .count    (r_reg.delayCount),
        .done     (delayDone)
    );

    // ****************************************************************
    // instruction framing
    // ****************************************************************
    function automatic logic [31:0] build_frame(ssp_cmd_e op, logic [15:0] a, logic [7:0] d);
        logic [15:0] page;
        page = a & `SSP_PAGE_MASK;
        // unused bytes go out as fill
        unique case (op)
            SSP_CMD_ENTER:      build_frame = {`SSP_OP_ENABLE, `SSP_ENABLE_ECHO,
                                               `SSP_FILL, `SSP_FILL};
            SSP_CMD_ERASE:      build_frame = {`SSP_OP_ENABLE, `SSP_ERASE_B2,
                                               `SSP_FILL, `SSP_FILL};
            SSP_CMD_LOAD_LO:    build_frame = {`SSP_OP_LOAD_LO, a, d};
            SSP_CMD_LOAD_HI:    build_frame = {`SSP_OP_LOAD_HI, a, d};
            SSP_CMD_WRITE_PAGE: build_frame = {`SSP_OP_WR_PAGE, page, `SSP_FILL};
            SSP_CMD_WRITE_EE:   build_frame = {`SSP_OP_WR_EE, a, d};
            SSP_CMD_READ_LO:    build_frame = {`SSP_OP_RD_LO, a, `SSP_FILL};
            SSP_CMD_READ_HI:    build_frame = {`SSP_OP_RD_HI, a, `SSP_FILL};
            SSP_CMD_READ_EE:    build_frame = {`SSP_OP_RD_EE, a, `SSP_FILL};
            SSP_CMD_POLL:       build_frame = {`SSP_OP_POLL, `SSP_FILL,
                                               `SSP_FILL, `SSP_FILL};
            default:            build_frame = '0;
        endcase
    endfunction

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        r_next            = r_reg;
        r_next.rspValid   = 1'b0;
        r_next.shiftStart = 1'b0;
        r_next.delayLoad  = 1'b0;
        r_next.misoMeta   = miso;
        r_next.misoSync   = r_reg.misoMeta;
        unique case (r_reg.state)
            SSP_ST_BOOT: begin
                // reset and sck are both low from reset onward
                r_next.delayLoad  = 1'b1;
                r_next.delayCount = PWRUP_LEN;
                r_next.state      = SSP_ST_PWRUP;
            end
            SSP_ST_PWRUP: begin
                if (delayDone) begin
                    // entry was asked while the target ran
                    if (r_reg.pendEnter) begin
                        r_next.pendEnter  = 1'b0;
                        r_next.shiftStart = 1'b1;
                        r_next.state      = SSP_ST_SEND;
                    end else begin
                        r_next.cmdReady = 1'b1;
                        r_next.state    = SSP_ST_IDLE;
                    end
                end
            end
            SSP_ST_IDLE: begin
                if (cmdValid && r_reg.cmdReady) begin
                    r_next.cmdReady = 1'b0;
                    r_next.op       = cmdOp;
                    r_next.addr     = cmdAddr;
                    r_next.data     = cmdData;
                    r_next.frame    = build_frame(cmdOp, cmdAddr, cmdData);
                    r_next.rspData  = 8'h00;
                    r_next.rspError = 1'b0;
                    if (cmdOp == SSP_CMD_RELEASE) begin
                        // entry must be redone after this
                        r_next.devResetN = 1'b1;
                        r_next.synced    = 1'b0;
                        r_next.loValid   = 1'b0;
                        r_next.rspValid  = 1'b1;
                        r_next.cmdReady  = 1'b1;
                    end else if (cmdOp == SSP_CMD_ENTER) begin
                        r_next.retries = RETRY_MAX;
                        if (r_reg.devResetN) begin
                            // target was running: hold it and let it settle
                            r_next.devResetN  = 1'b0;
                            r_next.pendEnter  = 1'b1;
                            r_next.delayLoad  = 1'b1;
                            r_next.delayCount = PWRUP_LEN;
                            r_next.state      = SSP_ST_PWRUP;
                        end else begin
                            r_next.shiftStart = 1'b1;
                            r_next.state      = SSP_ST_SEND;
                        end
                    end else if (!r_reg.synced) begin
                        r_next.rspError = 1'b1;
                        r_next.rspValid = 1'b1;
                        r_next.cmdReady = 1'b1;
                    end else if (cmdOp == SSP_CMD_LOAD_HI &&
                                 !(r_reg.loValid && r_reg.loAddr == cmdAddr)) begin
                        // a lone high byte would load half a word
                        r_next.rspError = 1'b1;
                        r_next.rspValid = 1'b1;
                        r_next.cmdReady = 1'b1;
                    end else begin
                        r_next.shiftStart = 1'b1;
                        r_next.state      = SSP_ST_SEND;
                    end
                end
            end
            SSP_ST_SEND: begin
                if (shiftDone) begin
                    r_next.rspData = rxFrame[7:0];
                    unique case (r_reg.op)
                        SSP_CMD_ENTER: begin
                            // the echo rides in the third byte slot
                            if (rxFrame[`SSP_ECHO_MSB:`SSP_ECHO_LSB] ==
                                `SSP_ENABLE_ECHO) begin
                                r_next.synced   = 1'b1;
                                r_next.rspValid = 1'b1;
                                r_next.cmdReady = 1'b1;
                                r_next.state    = SSP_ST_IDLE;
                            end else if (r_reg.retries == 4'h0) begin
                                // give up; caller may retry
                                r_next.synced   = 1'b0;
                                r_next.rspError = 1'b1;
                                r_next.rspValid = 1'b1;
                                r_next.cmdReady = 1'b1;
                                r_next.state    = SSP_ST_IDLE;
                            end else begin
                                r_next.retries    = r_reg.retries - 4'h1;
                                r_next.devResetN  = 1'b1;
                                r_next.delayLoad  = 1'b1;
                                r_next.delayCount = PULSE_LEN;
                                r_next.state      = SSP_ST_PULSE;
                            end
                        end
                        SSP_CMD_ERASE: begin
                            // loaded bytes are gone
                            r_next.loValid    = 1'b0;
                            r_next.delayLoad  = 1'b1;
                            r_next.delayCount = ERASE_LEN;
                            r_next.state      = SSP_ST_WAIT;
                        end
                        SSP_CMD_WRITE_PAGE: begin
                            // fixed wait covers all-ones data that polling misses
                            r_next.loValid    = 1'b0;
                            r_next.delayLoad  = 1'b1;
                            r_next.delayCount = FLASH_LEN;
                            r_next.state      = SSP_ST_WAIT;
                        end
                        SSP_CMD_WRITE_EE: begin
                            // no erase needed first
                            r_next.delayLoad  = 1'b1;
                            r_next.delayCount = EEPROM_LEN;
                            r_next.state      = SSP_ST_WAIT;
                        end
                        default: begin
                            // ends with the frame
                            if (r_reg.op == SSP_CMD_LOAD_LO) begin
                                r_next.loValid = 1'b1;
                                r_next.loAddr  = r_reg.addr;
                            end else if (r_reg.op == SSP_CMD_LOAD_HI) begin
                                r_next.loValid = 1'b0;
                            end
                            r_next.rspValid = 1'b1;
                            r_next.cmdReady = 1'b1;
                            r_next.state    = SSP_ST_IDLE;
                        end
                    endcase
                end
            end
            SSP_ST_WAIT: begin
                if (delayDone) begin
                    r_next.rspValid = 1'b1;
                    r_next.cmdReady = 1'b1;
                    r_next.state    = SSP_ST_IDLE;
                end
            end
            SSP_ST_PULSE: begin
                // devResetN stays high through the pulse, so the target's bit count restarts
                if (delayDone) begin
                    r_next.devResetN  = 1'b0;
                    r_next.shiftStart = 1'b1;
                    r_next.state      = SSP_ST_SEND;
                end
            end
            default: begin
                r_next.state = SSP_ST_BOOT;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            r_reg       <= '0;
            r_reg.state <= SSP_ST_BOOT;
            r_reg.op    <= SSP_CMD_ENTER;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cmdReady   = r_reg.cmdReady;
    assign rspValid   = r_reg.rspValid;
    assign rspData    = r_reg.rspData;
    assign rspError   = r_reg.rspError;
    assign linkSynced = r_reg.synced;
    assign devResetN  = r_reg.devResetN;
endmodule // ssp_programmer
`default_nettype wire

// file: ssp_target_model.sv
// behavioural target memory behind the serial programming pins
`default_nettype none
module ssp_target_model #(
    parameter int BUSY_NS = 500
) (
    input  wire logic devResetN,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  fl [256], ee [256], pb [128], ob = 8'h00;
    logic [31:0] rx = '0;
    logic [5:0]  n = '0;
    logic        en = 1'b0, q = 1'b0, bsy;
    time         busyTo = 0;
    // a released pin floats: show the inverse, never a stale bit
    assign miso = devResetN ? ~q : q;
    initial foreach (fl[i]) {fl[i], ee[i]} = 16'h0000;
    always @(negedge sck) begin
        q = ob[7];
        ob = {ob[6:0], 1'b0};
    end
    always @(posedge sck or posedge devResetN) begin
        bsy = $time < busyTo;
        if (devResetN) begin
            n = '0;
            en = 1'b0;
        end else begin
            rx = {rx[30:0], mosi};
            n = n + 6'h01;
            if (n == 6'h10) ob = rx[7:0];
            if (n == 6'h18 && en) case (rx[23:16])
                8'h20: ob = bsy ? 8'hff : fl[{rx[6:0], 1'b0}];
                8'h28: ob = bsy ? 8'hff : fl[{rx[6:0], 1'b1}];
                8'ha0: ob = bsy ? 8'hff : ee[rx[7:0]];
                8'hf0: ob = {7'h00, bsy};
                default: ob = 8'h00;
            endcase
            if (n == 6'h20) begin
                n = '0;
                if (rx[31:16] == 16'hac53) en = 1'b1;
                else if (en) begin
                    if (rx[31:16] == 16'hac80) foreach (fl[i]) {fl[i], ee[i]} = 16'hffff;
                    if (rx[31:24] == 8'h40) pb[{rx[13:8], 1'b0}] = rx[7:0];
                    if (rx[31:24] == 8'h48) pb[{rx[13:8], 1'b1}] = rx[7:0];
                    if (rx[31:24] == 8'h4c) foreach (pb[j]) fl[{rx[14], 7'(j)}] = pb[j];
                    if (rx[31:24] == 8'hc0) ee[rx[15:8]] = rx[7:0];
                    busyTo = $time + BUSY_NS;
                end
            end
        end
    end
endmodule // ssp_target_model
`default_nettype wire

// file: ssp_programmer_chk.sv
// port assertions for the serial programmer
`default_nettype none
module ssp_programmer_chk
    import ssp_pkg::*;
#(parameter int PWRUP_CYC = 50) (
    input wire logic     clk_sys, reset_n, cmdValid, cmdReady, rspValid, rspError,
    input wire ssp_cmd_e cmdOp,
    input wire logic     linkSynced, devResetN, sck, mosi
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [19:0] upCnt_reg;
    // cycles since reset release, saturating
    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n) upCnt_reg <= '0;
        else upCnt_reg <= upCnt_reg + 20'(upCnt_reg != '1);
    a_sck_low_min: assert property ($fell(sck) |-> !sck [*3])
        else $error("sck low too short");
    a_sck_high_min: assert property ($rose(sck) |-> sck [*3])
        else $error("sck high too short");
    a_mosi_hold: assert property (sck |-> $stable(mosi))
        else $error("mosi moved while sck high");
    a_pin_released: assert property (devResetN |-> !sck)
        else $error("sck toggles with target released");
    a_pwrup_wait: assert property ($rose(sck) |-> upCnt_reg >= PWRUP_CYC)
        else $error("entry sent before power-up wait");
    a_refuse_early: assert property (cmdValid && cmdReady && !linkSynced &&
        !(cmdOp inside {SSP_CMD_ENTER, SSP_CMD_RELEASE}) |=> rspValid && rspError)
        else $error("command not refused before entry");
    a_release_pin: assert property (cmdValid && cmdReady && cmdOp == SSP_CMD_RELEASE |-> ##[1:2] devResetN)
        else $error("release did not raise target reset");
    a_sync_answer: assert property ($rose(linkSynced) |-> ##[0:2] (rspValid && !rspError))
        else $error("sync without good answer");
    a_idle_quiet: assert property (cmdReady |-> !sck)
        else $error("sck active while idle");
    cover property (cmdValid && cmdReady && cmdOp == SSP_CMD_WRITE_PAGE);
    cover property ($rose(linkSynced));
    cover property (rspValid && rspError);
endmodule // ssp_programmer_chk
bind ssp_programmer ssp_programmer_chk #(.PWRUP_CYC(PWRUP_CYC)) ssp_programmer_chk_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspError(rspError), .cmdOp(cmdOp), .linkSynced(linkSynced),
    .devResetN(devResetN), .sck(sck), .mosi(mosi));
`default_nettype wire

// file: ssp_programmer_test.sv
// self-checking bench for the serial programmer
`default_nettype none
module ssp_programmer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ssp_pkg::*;
    // val is write data for writes and the expected byte for reads
    typedef struct packed {ssp_cmd_e op; logic [15:0] addr; logic [7:0] val; logic chk, err;} ssp_row_s;
    logic clk_sys, reset_n, cmdValid, cmdReady, rspValid, rspError, linkSynced;
    logic devResetN, sck, mosi, miso;
    ssp_cmd_e cmdOp;
    logic [15:0] cmdAddr;
    logic [7:0] cmdData, rspData;
    int errCount = 0, nTests = 0;
    ssp_row_s rows [15] = '{
        '{SSP_CMD_LOAD_LO, 16'h0042, 8'ha5, 1'b0, 1'b1},
        '{SSP_CMD_ENTER, 16'h0000, 8'h00, 1'b0, 1'b0},
        '{SSP_CMD_ERASE, 16'h0000, 8'h00, 1'b0, 1'b0},
        '{SSP_CMD_READ_EE, 16'h0005, 8'hff, 1'b1, 1'b0},
        '{SSP_CMD_WRITE_EE, 16'h0005, 8'h3c, 1'b0, 1'b0},
        '{SSP_CMD_READ_EE, 16'h0005, 8'h3c, 1'b1, 1'b0},
        '{SSP_CMD_LOAD_LO, 16'h0042, 8'ha5, 1'b0, 1'b0},
        '{SSP_CMD_LOAD_HI, 16'h0042, 8'h5a, 1'b0, 1'b0},
        '{SSP_CMD_WRITE_PAGE, 16'h0042, 8'h00, 1'b0, 1'b0},
        '{SSP_CMD_READ_LO, 16'h0042, 8'ha5, 1'b1, 1'b0},
        '{SSP_CMD_READ_HI, 16'h0042, 8'h5a, 1'b1, 1'b0},
        '{SSP_CMD_LOAD_HI, 16'h0043, 8'h11, 1'b0, 1'b1},
        '{SSP_CMD_POLL, 16'h0000, 8'h00, 1'b1, 1'b0},
        '{SSP_CMD_RELEASE, 16'h0000, 8'h00, 1'b0, 1'b0},
        '{SSP_CMD_ENTER, 16'h0000, 8'h00, 1'b0, 1'b0}};
    ssp_programmer #(.PWRUP_CYC(50), .FLASH_CYC(20), .EEPROM_CYC(30), .ERASE_CYC(30),
        .PULSE_CYC(4)) ssp_programmer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
        .linkSynced(linkSynced), .devResetN(devResetN), .sck(sck), .mosi(mosi), .miso(miso));
    ssp_target_model ssp_target_model_inst (.devResetN(devResetN), .sck(sck), .mosi(mosi),
        .miso(miso));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input ssp_row_s r);
        int k;
        @(posedge clk_sys);
        #1 cmdValid = 1'b1;
        cmdOp = r.op;
        cmdAddr = r.addr;
        cmdData = r.val;
        // look just after each edge, where registered outputs have settled
        for (k = 0; cmdReady !== 1'b1 && k < 9000; k++) @(posedge clk_sys) #1;
        if (k == 9000) errCount++;
        @(posedge clk_sys);
        #1 cmdValid = 1'b0;
        for (k = 0; rspValid !== 1'b1 && k < 9000; k++) @(posedge clk_sys) #1;
        if (k == 9000) errCount++;
        cmp({7'h00, rspError}, {7'h00, r.err});
        if (r.chk) cmp(rspData, r.val);
        $display("done op %h", r.op);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #1500000;
        errCount++;
        finishTest();
    end
    initial begin
        {reset_n, cmdValid, cmdAddr, cmdData} = '0;
        cmdOp = SSP_CMD_ENTER;
        repeat (12) @(posedge clk_sys);
        cmp({5'h00, devResetN, sck, cmdReady}, 8'h00);
        $display("reset test done");
        #1 reset_n = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // reset in mid-frame leaves the target out of step; entry must recover
        @(posedge clk_sys);
        #1 cmdValid = 1'b1;
        cmdOp = SSP_CMD_READ_EE;
        repeat (40) @(posedge clk_sys);
        #1 {reset_n, cmdValid} = 2'b00;
        @(posedge clk_sys);
        cmp({6'h00, devResetN, sck}, 8'h00);
        #1 reset_n = 1'b1;
        run('{SSP_CMD_ENTER, 16'h0000, 8'h00, 1'b0, 1'b0});
        cmp({7'h00, linkSynced}, 8'h01);
        $display("mid-run reset test done");
        finishTest();
    end
endmodule // ssp_programmer_test
`default_nettype wire
